// ==== isd_pkg.sv ====
// Shared constants, types and encodings for the instruction subset decoder
package isd_pkg;

  // ==========================================================
  // Quarter-cycle phases
  // ==========================================================
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } phase_t;

  // ==========================================================
  // Instruction word fields and opcode patterns
  // ==========================================================
  localparam logic [15:0] IDLE_WORD = 16'h0000;
  localparam logic [15:0] KICK_WORD = 16'h0004;
  localparam logic [4:0] JUMP_PREFIX = 5'h1A;
  localparam logic [3:0] BITSET_PREFIX = 4'h8;
  localparam logic [6:0] ZERO_PREFIX = 7'h35;
  localparam logic [6:0] NEGATE_PREFIX = 7'h36;
  localparam logic [3:0] IDLE_PREFIX = 4'hF;

  // ==========================================================
  // Address widths and access bank layout
  // ==========================================================
  localparam int PC_W = 21;
  localparam int DADDR_W = 12;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h00_0000;

  // ==========================================================
  // Status bit positions in the status register
  // ==========================================================
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;
  localparam int ST_N = 4;
  localparam int ST_TO = 8;
  localparam int ST_PD = 9;
  localparam logic [9:0] STATUS_RESET = 10'h300;
  localparam logic [9:0] STATUS_MASK = 10'h31F;

  // ==========================================================
  // Register map, byte addresses
  // ==========================================================
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BANK = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0C;
  localparam logic [7:0] REG_KICKS = 8'h10;
  localparam int CTRL_RUN = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [3:0] BANK_RESET = 4'h0;

  // ==========================================================
  // Bus encodings
  // ==========================================================
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

endpackage : isd_pkg

// ==== isd_phase_gen.sv ====
// Quarter-cycle phase sequencer for the instruction cycle
`timescale 1ns/1ps
`default_nettype none

module isd_phase_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic run_i,
  // Phase
  output isd_pkg::phase_t phase_o
);

  isd_pkg::phase_t next_phase; // Phase after this edge

  // ==========================================================
  // Phase advance
  // ==========================================================
  // A halted core parks in Q1 so a restart always begins cleanly
  always_comb begin
    unique case (phase_o)
      isd_pkg::PH_Q1: next_phase = run_i ? isd_pkg::PH_Q2 : isd_pkg::PH_Q1;
      isd_pkg::PH_Q2: next_phase = isd_pkg::PH_Q3;
      isd_pkg::PH_Q3: next_phase = isd_pkg::PH_Q4;
      isd_pkg::PH_Q4: next_phase = isd_pkg::PH_Q1;
      default: next_phase = isd_pkg::PH_Q1; // Illegal code recovers
    endcase
  end

  // Phase register
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase_o <= isd_pkg::PH_Q1;
    end else begin
      phase_o <= next_phase;
    end
  end

endmodule : isd_phase_gen

`default_nettype wire

// ==== isd_negate_unit.sv ====
// Two's complement negation with its status flags
`timescale 1ns/1ps
`default_nettype none

module isd_negate_unit (
  // Operand
  input wire logic [7:0] value_i,
  // Result and flags
  output logic [7:0] result_o,
  output logic neg_o,
  output logic ovf_o,
  output logic carry_o,
  output logic digit_carry_o,
  output logic zero_o
);

  wire logic [8:0] full_sum; // Inverted operand plus one, with carry out
  wire logic [4:0] low_sum; // Low nibble sum, with carry out

  // ==========================================================
  // Arithmetic
  // ==========================================================
  // Carries come from the real adder, not from special cases
  assign full_sum = {1'b0, ~value_i} + 9'h001;
  assign low_sum = {1'b0, ~value_i[3:0]} + 5'h01;
  assign result_o = full_sum[7:0];
  assign carry_o = full_sum[8];
  assign digit_carry_o = low_sum[4];
  assign neg_o = full_sum[7];
  assign zero_o = (full_sum[7:0] == 8'h00);
  // Only the most negative value overflows on negation
  assign ovf_o = value_i[7] & full_sum[7];

endmodule : isd_negate_unit

`default_nettype wire

// ==== isd_core.sv ====
// Decode and execute logic for the instruction subset, with its register slave
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module isd_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register bus
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Program memory
  output logic [isd_pkg::PC_W-1:0] prog_addr_o,
  input wire logic [15:0] instr_i,
  // Data memory
  output logic [isd_pkg::DADDR_W-1:0] dmem_addr_o,
  input wire logic [7:0] dmem_rdata_i,
  output logic [7:0] dmem_wdata_o,
  output logic dmem_we_o,
  // Watchdog
  output logic wdt_counter_clear_o,
  output logic wdt_postscaler_clear_o
);

  // ==========================================================
  // Declarations
  // ==========================================================
  isd_pkg::phase_t phase; // Current quarter of the cycle
  logic [31:0] ctrl; // Control register, run bit
  logic [3:0] bank_select_reg; // Bank used when access flag is one
  logic [9:0] status; // Arithmetic flags plus timeout and powerdown
  logic [isd_pkg::PC_W-1:0] pc; // Byte address of the current word
  logic [31:0] kick_count; // Executed watchdog kicks
  logic [15:0] ir; // Instruction held for the cycle
  logic flush; // Next fetched word is dropped
  logic [7:0] operand; // File value read in Q2
  logic [7:0] result; // Value to write back in Q4
  logic [4:0] flag_result; // Flags computed in Q3
  logic flag_write; // Q4 updates arithmetic flags
  logic wdt_pulse; // Watchdog clear strobe
  logic bus_pending; // A bus transfer is in its data phase
  logic bus_write; // Pending transfer is a write
  logic [7:0] bus_addr; // Pending byte address
  wire logic run; // Core may advance

  // Decoded instruction classes
  wire logic relative_jump_op;
  wire logic bit_force_one_op;
  wire logic file_zero_op;
  wire logic watchdog_kick_op;
  wire logic file_twos_negate_op;
  wire logic idle_op;
  wire logic file_op; // Any instruction that writes a file

  // Datapath values
  wire logic [2:0] bit_index;
  wire logic [7:0] bit_mask;
  wire logic [isd_pkg::PC_W-1:0] jump_offset;
  wire logic [isd_pkg::PC_W-1:0] next_pc;
  wire logic [7:0] neg_result;
  wire logic neg_n, neg_ov, neg_c, neg_dc, neg_z;
  wire logic [7:0] next_result;
  wire logic [4:0] next_flags;
  wire logic [15:0] fetched; // Word that enters decode
  wire logic [isd_pkg::DADDR_W-1:0] next_dmem_addr;

  // Bus decoding
  wire logic bus_take;
  wire logic bus_wr;
  wire logic [31:0] read_mux;
  wire logic [9:0] status_hw_set;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Full data address from access flag, bank and file address
  function automatic logic [isd_pkg::DADDR_W-1:0] file_address(
    input logic access_flag,
    input logic [3:0] bank,
    input logic [7:0] file
  );
    logic [3:0] upper;
    upper = file[7] ? isd_pkg::ACCESS_HIGH_BANK : isd_pkg::ACCESS_LOW_BANK;
    file_address = access_flag ? {bank, file} : {upper, file};
  endfunction : file_address

  // ==========================================================
  // Sub-blocks
  // ==========================================================
  isd_phase_gen u_phase (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .run_i(run),
    .phase_o(phase)
  );

  isd_negate_unit u_negate (
    .value_i(operand),
    .result_o(neg_result),
    .neg_o(neg_n),
    .ovf_o(neg_ov),
    .carry_o(neg_c),
    .digit_carry_o(neg_dc),
    .zero_o(neg_z)
  );

  // ==========================================================
  // Decode
  // ==========================================================
  assign run = ctrl[isd_pkg::CTRL_RUN];
  assign fetched = flush ? isd_pkg::IDLE_WORD : instr_i;
  assign relative_jump_op = (ir[15:11] == isd_pkg::JUMP_PREFIX);
  assign bit_force_one_op = (ir[15:12] == isd_pkg::BITSET_PREFIX);
  assign file_zero_op = (ir[15:9] == isd_pkg::ZERO_PREFIX);
  assign watchdog_kick_op = (ir == isd_pkg::KICK_WORD);
  assign file_twos_negate_op = (ir[15:9] == isd_pkg::NEGATE_PREFIX);
  assign idle_op = (ir == isd_pkg::IDLE_WORD) || (ir[15:12] == isd_pkg::IDLE_PREFIX);
  // An idle word never reaches the file write path, whatever its low bits say
  assign file_op = (bit_force_one_op | file_zero_op | file_twos_negate_op) & ~idle_op;
  assign next_dmem_addr = file_address(fetched[8], bank_select_reg, fetched[7:0]);

  // ==========================================================
  // Execute datapath
  // ==========================================================
  assign bit_index = ir[11:9];
  assign bit_mask = 8'h01 << bit_index;
  assign jump_offset = {{(isd_pkg::PC_W-12){ir[10]}}, ir[10:0], 1'b0};
  assign next_pc = relative_jump_op ? (pc + isd_pkg::PC_STEP + jump_offset)
                                    : (pc + isd_pkg::PC_STEP);
  assign next_result = bit_force_one_op ? (operand | bit_mask) :
                       file_twos_negate_op ? neg_result : 8'h00;
  // negate flags, N OV Z DC C
  assign next_flags = file_twos_negate_op ? {neg_n, neg_ov, neg_z, neg_dc, neg_c}
                                          : {status[isd_pkg::ST_N], status[isd_pkg::ST_OV],
                                             1'b1, status[isd_pkg::ST_DC],
                                             status[isd_pkg::ST_C]};

  // ==========================================================
  // Instruction cycle
  // ==========================================================
  // Q1 edge: fetch into decode
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ir <= isd_pkg::IDLE_WORD;
      dmem_addr_o <= '0;
    end else if (phase == isd_pkg::PH_Q1 && run) begin
      ir <= fetched;
      dmem_addr_o <= next_dmem_addr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      operand <= 8'h00;
    end else if (phase == isd_pkg::PH_Q2 && file_op) begin
      operand <= dmem_rdata_i;
    end
  end

  // Q3 edge: compute result and flags
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      result <= 8'h00;
      flag_result <= 5'h00;
      flag_write <= 1'b0;
    end else if (phase == isd_pkg::PH_Q3) begin
      result <= next_result;
      flag_result <= next_flags;
      flag_write <= file_zero_op | file_twos_negate_op;
    end
  end

  // Write strobe stands through Q4 only
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dmem_we_o <= 1'b0;
    end else begin
      dmem_we_o <= (phase == isd_pkg::PH_Q3) && file_op;
    end
  end
  assign dmem_wdata_o = result;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdt_pulse <= 1'b0;
    end else begin
      wdt_pulse <= (phase == isd_pkg::PH_Q2) && watchdog_kick_op;
    end
  end
  assign wdt_counter_clear_o = wdt_pulse;
  assign wdt_postscaler_clear_o = wdt_pulse;

  // PC written at Q4; jump flushes one word
  // The dropped cycle holds the PC, so the jump target runs right after it
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pc <= isd_pkg::PC_RESET;
      flush <= 1'b0;
    end else if (phase == isd_pkg::PH_Q4) begin
      pc <= flush ? pc : next_pc;
      flush <= relative_jump_op;
    end
  end
  assign prog_addr_o = pc;

  // ==========================================================
  // Register bus slave
  // ==========================================================
  // Zero wait state: every transfer completes in its first data cycle
  assign hreadyout_o = 1'b1;
  assign hresp_o = isd_pkg::HRESP_OKAY;
  assign bus_take = hsel_i && hready_i && (htrans_i == isd_pkg::HTRANS_NONSEQ);
  assign bus_wr = bus_pending && bus_write;

  // Address phase capture
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_pending <= 1'b0;
      bus_write <= 1'b0;
      bus_addr <= 8'h00;
    end else if (hready_i) begin
      bus_pending <= bus_take;
      bus_write <= hwrite_i;
      bus_addr <= haddr_i[7:0];
    end
  end

  // Read data, registered from the address phase; unmapped reads give zero
  assign read_mux =
    (haddr_i[7:0] == isd_pkg::REG_CTRL) ? ctrl :
    (haddr_i[7:0] == isd_pkg::REG_BANK) ? {28'h000_0000, bank_select_reg} :
    (haddr_i[7:0] == isd_pkg::REG_STATUS) ? {22'h00_0000, status} :
    (haddr_i[7:0] == isd_pkg::REG_PC) ? {11'h000, pc} :
    (haddr_i[7:0] == isd_pkg::REG_KICKS) ? kick_count : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (bus_take && !hwrite_i) begin
      hrdata_o <= read_mux;
    end
  end

  // Control and bank registers; bank changes take effect at the next decode
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl <= isd_pkg::CTRL_RESET;
      bank_select_reg <= isd_pkg::BANK_RESET;
    end else if (bus_wr && bus_addr == isd_pkg::REG_CTRL) begin
      ctrl <= hwdata_i & (32'h0000_0001 << isd_pkg::CTRL_RUN);
    end else if (bus_wr && bus_addr == isd_pkg::REG_BANK) begin
      bank_select_reg <= hwdata_i[3:0];
    end
  end

  // ==========================================================
  // Status register
  // ==========================================================
  // Kick sets timeout and powerdown; hardware wins over software
  assign status_hw_set = wdt_pulse ? ((10'h001 << isd_pkg::ST_TO) | (10'h001 << isd_pkg::ST_PD))
                                   : 10'h000;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      status <= isd_pkg::STATUS_RESET;
    end else begin
      if (bus_wr && bus_addr == isd_pkg::REG_STATUS) begin
        status <= (hwdata_i[9:0] & isd_pkg::STATUS_MASK) | status_hw_set;
      end else begin
        status <= status | status_hw_set;
      end
      // flags only from register-modifying ops; beats software
      if (phase == isd_pkg::PH_Q4 && flag_write) begin
        status[isd_pkg::ST_N:isd_pkg::ST_C] <= flag_result;
      end
    end
  end

  // Kick counter, useful to see the watchdog being serviced
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      kick_count <= 32'h0000_0000;
    end else if (wdt_pulse) begin
      kick_count <= kick_count + 32'h0000_0001;
    end
  end

endmodule : isd_core

`default_nettype wire

// ==== isd_core_monitor.sv ====
// Port checker for the instruction subset decoder core
`timescale 1ns/1ps
`default_nettype none
module isd_core_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Program memory
  input wire logic [isd_pkg::PC_W-1:0] prog_addr_o,
  input wire logic [15:0] instr_i,
  // Data memory and watchdog
  input wire logic [isd_pkg::DADDR_W-1:0] dmem_addr_o,
  input wire logic [7:0] dmem_rdata_i,
  input wire logic [7:0] dmem_wdata_o,
  input wire logic dmem_we_o,
  input wire logic wdt_counter_clear_o,
  input wire logic wdt_postscaler_clear_o
);
  // ==========================================
  // Helpers
  // ==========================================
  // Instr_i still shows the running word in Q4, as the PC moves only at its end
  wire logic [20:0] jump_delta = {{9{instr_i[10]}}, instr_i[10:0], 1'b0};
  // Any visible action of an instruction
  wire logic acts = dmem_we_o || wdt_counter_clear_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================
  // Assertions
  // ==========================================
  chk_jump_target: assert property (
    ($changed(prog_addr_o) && $past(instr_i[15:11]) == isd_pkg::JUMP_PREFIX)
    |-> prog_addr_o == $past(prog_addr_o) + $past(jump_delta) + isd_pkg::PC_STEP)
    else $error("jump target wrong");
  chk_jump_idle: assert property (
    ($changed(prog_addr_o) && prog_addr_o != $past(prog_addr_o) + isd_pkg::PC_STEP)
    |-> !acts [*4])
    else $error("action in idle cycle after jump");
  chk_force_data: assert property (
    (dmem_we_o && instr_i[15:12] == isd_pkg::BITSET_PREFIX)
    |-> dmem_wdata_o == (dmem_rdata_i | (8'h01 << instr_i[11:9])))
    else $error("bit force data wrong");
  chk_access_bank: assert property (
    (dmem_we_o && !instr_i[8]) |-> dmem_addr_o == {(instr_i[7] ?
    isd_pkg::ACCESS_HIGH_BANK : isd_pkg::ACCESS_LOW_BANK), instr_i[7:0]})
    else $error("access bank address wrong");
  chk_zero_data: assert property (
    (dmem_we_o && instr_i[15:9] == isd_pkg::ZERO_PREFIX) |-> dmem_wdata_o == 8'h00)
    else $error("file zero data wrong");
  chk_kick_pulse: assert property (
    (wdt_counter_clear_o || wdt_postscaler_clear_o) |-> (wdt_counter_clear_o &&
    wdt_postscaler_clear_o && instr_i == isd_pkg::KICK_WORD) ##1 !acts)
    else $error("watchdog clear pulse wrong");
  chk_negate_data: assert property (
    (dmem_we_o && instr_i[15:9] == isd_pkg::NEGATE_PREFIX)
    |-> dmem_wdata_o == 8'h00 - dmem_rdata_i)
    else $error("negate data wrong");
  chk_idle_quiet: assert property (
    acts |-> instr_i != isd_pkg::IDLE_WORD && instr_i[15:12] != isd_pkg::IDLE_PREFIX)
    else $error("idle word acted");
  chk_write_spacing: assert property (
    dmem_we_o |=> !dmem_we_o [*3])
    else $error("writes closer than one cycle");
  chk_write_advance: assert property (
    dmem_we_o |=> prog_addr_o == $past(prog_addr_o) + isd_pkg::PC_STEP)
    else $error("pc not advanced after write");
  // Main scenarios reached
  cov_force: cover property (dmem_we_o && instr_i[15:12] == isd_pkg::BITSET_PREFIX);
  cov_kick: cover property (wdt_counter_clear_o);
  cov_jump: cover property ($changed(prog_addr_o) && $past(instr_i[15:11]) == 5'h1a);
endmodule : isd_core_monitor

bind isd_core isd_core_monitor u_isd_core_monitor (
  .clk_i(clk_i), .reset_i(reset_i), .prog_addr_o(prog_addr_o), .instr_i(instr_i),
  .dmem_addr_o(dmem_addr_o), .dmem_rdata_i(dmem_rdata_i), .dmem_wdata_o(dmem_wdata_o),
  .dmem_we_o(dmem_we_o), .wdt_counter_clear_o(wdt_counter_clear_o),
  .wdt_postscaler_clear_o(wdt_postscaler_clear_o));
`default_nettype wire

// ==== isd_mem_model.sv ====
// Program and banked data memory model facing the decoder core
`timescale 1ns/1ps
`default_nettype none
module isd_mem_model (
  // Clock
  input wire logic clk_i,
  // Program memory
  input wire logic [isd_pkg::PC_W-1:0] prog_addr_i,
  output logic [15:0] instr_o,
  // Data memory
  input wire logic [isd_pkg::DADDR_W-1:0] dmem_addr_i,
  output logic [7:0] dmem_rdata_o,
  input wire logic [7:0] dmem_wdata_i,
  input wire logic dmem_we_i
);
  // Word store; unloaded words hold idle words
  logic [15:0] prog [0:1023];
  // Byte store for all sixteen banks
  logic [7:0] dmem [0:4095];
  // Fill varies with the low address byte, so a wrong file never reads a lucky match; all sixteen banks repeat it
  initial begin
    for (int i = 0; i < 4096; i++) begin
      dmem[i] = i[7:0] ^ 8'h5a;
    end
    for (int i = 0; i < 1024; i++) begin
      prog[i] = 16'hf000;
    end
  end
  // Reads answer within the cycle
  assign instr_o = prog[prog_addr_i[10:1]];
  assign dmem_rdata_o = dmem[dmem_addr_i];
  // Writes land at the edge closing Q4
  always @(posedge clk_i) begin
    if (dmem_we_i) begin
      dmem[dmem_addr_i] <= dmem_wdata_i;
    end
  end
endmodule : isd_mem_model
`default_nettype wire

// ==== mcu_instruction_subset_decoder_tb_top.sv ====
// Self-checking bench for the instruction subset decoder
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_subset_decoder_tb_top;
  // Row: word, data address, bank, byte before and after, status before and after
  typedef struct packed {
    logic [15:0] instr;
    logic [11:0] addr;
    logic [3:0] bank;
    logic [7:0] pre;
    logic [7:0] exp;
    logic [9:0] st_pre;
    logic [9:0] st_exp;
  } row_t;
  localparam row_t ROWS [10] = '{
    '{16'h8f12, 12'h312, 4'h3, 8'h0a, 8'h8a, 10'h31f, 10'h31f},
    '{16'h8090, 12'hf90, 4'h5, 8'hfe, 8'hff, 10'h000, 10'h000},
    '{16'h6a20, 12'h020, 4'h7, 8'h5a, 8'h00, 10'h31b, 10'h31f},
    '{16'h6b80, 12'h280, 4'h2, 8'h33, 8'h00, 10'h000, 10'h004},
    '{16'h6d44, 12'h144, 4'h1, 8'h3a, 8'hc6, 10'h30f, 10'h310},
    '{16'h6c05, 12'h005, 4'h9, 8'h80, 8'h80, 10'h000, 10'h01a},
    '{16'h6c06, 12'h006, 4'h0, 8'h00, 8'h00, 10'h318, 10'h307},
    '{16'h0004, 12'h010, 4'h0, 8'h11, 8'h11, 10'h01f, 10'h31f},
    '{16'h0000, 12'h011, 4'h0, 8'h22, 8'h22, 10'h015, 10'h015},
    '{16'hfabc, 12'h0bc, 4'h0, 8'h44, 8'h44, 10'h30a, 10'h30a}};
  // ==========================================
  // Signals
  // ==========================================
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [20:0] prog_addr;
  wire logic [15:0] instr;
  wire logic [11:0] daddr;
  wire logic [7:0] drdata;
  wire logic [7:0] dwdata;
  wire logic dwe;
  wire logic cnt_clr;
  wire logic ps_clr;
  int bad_count = 0;
  int tests_run = 0;
  int kicks = 0;
  isd_core u_isd_core (
    .clk_i(clk), .reset_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .prog_addr_o(prog_addr),
    .instr_i(instr), .dmem_addr_o(daddr), .dmem_rdata_i(drdata), .dmem_wdata_o(dwdata),
    .dmem_we_o(dwe), .wdt_counter_clear_o(cnt_clr), .wdt_postscaler_clear_o(ps_clr));
  isd_mem_model u_isd_mem_model (
    .clk_i(clk), .prog_addr_i(prog_addr), .instr_o(instr), .dmem_addr_i(daddr),
    .dmem_rdata_o(drdata), .dmem_wdata_i(dwdata), .dmem_we_i(dwe));
  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  // Counts watchdog clear pulses of the current row, counter and postscaler together
  always @(posedge clk) begin
    if (cnt_clr === 1'b1 && ps_clr === 1'b1) begin
      kicks++;
    end
  end
  // ==========================================
  // Tasks
  // ==========================================
  task automatic summarize();
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  // Bounded wait for the slave's ready at an edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      check(32'h0000_0000, 32'h0000_0001, "bus timeout");
      summarize();
    end
  endtask : wait_ready
  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= isd_pkg::HTRANS_NONSEQ;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : bus
  // Bounded wait until the PC shows a given address
  task automatic wait_pc(input logic [20:0] v);
    int n;
    n = 0;
    while (prog_addr !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      check(32'h0000_0000, 32'h0000_0001, "pc timeout");
      summarize();
    end
  endtask : wait_pc
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    logic [31:0] rd;
    row_t r;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, isd_pkg::REG_STATUS, 32'h0000_0000, rd);
    check(rd, 32'h0000_0300, "status reset");
    check({31'h0000_0000, hresp}, 32'h0000_0000, "okay response");
    // Read-only PC ignores a write; unmapped place reads zero
    bus(1'b1, isd_pkg::REG_PC, 32'h0000_0040, rd);
    bus(1'b0, isd_pkg::REG_PC, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000, "pc read only");
    bus(1'b0, 8'h20, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000, "unmapped read");
    $display("register test done");
    // One instruction per row, started from a fresh reset
    foreach (ROWS[i]) begin
      r = ROWS[i];
      do_reset();
      u_isd_mem_model.prog[0] = r.instr;
      u_isd_mem_model.dmem[r.addr] = r.pre;
      kicks = 0;
      bus(1'b1, isd_pkg::REG_BANK, {28'h000_0000, r.bank}, rd);
      bus(1'b1, isd_pkg::REG_STATUS, {22'h00_0000, r.st_pre}, rd);
      bus(1'b1, isd_pkg::REG_CTRL, 32'h0000_0001, rd);
      wait_pc(21'h0_0004);
      bus(1'b1, isd_pkg::REG_CTRL, 32'h0000_0000, rd);
      bus(1'b0, isd_pkg::REG_STATUS, 32'h0000_0000, rd);
      check(rd, {22'h00_0000, r.st_exp}, "status");
      check({24'h00_0000, u_isd_mem_model.dmem[r.addr]}, {24'h00_0000, r.exp}, "byte");
      check(kicks, {31'h0000_0000, r.instr == isd_pkg::KICK_WORD}, "kicks");
      $display("row %0d done", i);
    end
    // Forward jump skips the next word, backward jump returns to an idle word
    do_reset();
    u_isd_mem_model.prog[0] = 16'hd003;
    u_isd_mem_model.prog[1] = 16'h6a30;
    u_isd_mem_model.prog[4] = 16'h6a31;
    u_isd_mem_model.prog[5] = 16'hd7fd;
    u_isd_mem_model.dmem[12'h030] = 8'h77;
    u_isd_mem_model.dmem[12'h031] = 8'h77;
    bus(1'b1, isd_pkg::REG_CTRL, 32'h0000_0001, rd);
    wait_pc(21'h0_0006);
    bus(1'b1, isd_pkg::REG_CTRL, 32'h0000_0000, rd);
    check({24'h00_0000, u_isd_mem_model.dmem[12'h030]}, 32'h0000_0077, "skipped");
    check({24'h00_0000, u_isd_mem_model.dmem[12'h031]}, 32'h0000_0000, "target");
    $display("jump test done");
    summarize();
  end
endmodule : mcu_instruction_subset_decoder_tb_top
`default_nettype wire
